// ### src/core_special_registers.sv
// Special registers of a small 32-bit core: stacks, link, program counter,
// status word, priority mask and stack control, with the reset fetch.
// Assumes the pipeline drives one request per cycle and a vector read port
// that answers a read in a later cycle with i_vec_valid.
`timescale 1ns/10ps
`include "core_special_registers_defs.svh"

module core_special_registers
  import core_special_registers_pkg::*;
(
  input  wire logic        i_clk,            // Core clock
  input  wire logic        i_reset,          // Synchronous reset, high
  output logic             o_vec_req,        // Vector read request
  output logic [31:0]      o_vec_addr,       // Vector read address
  input  wire logic        i_vec_valid,      // Vector word returned
  input  wire logic [31:0] i_vec_data,       // Vector word
  output logic             o_running,        // Boot fetch done
  input  wire logic        i_msr_we,         // Move-to special register
  input  wire logic        i_mrs_re,         // Move-from special register
  input  wire logic [3:0]  i_sel,            // Special register selector
  input  wire logic [31:0] i_wdata,          // Move-to data
  output logic [31:0]      o_rdata,          // Move-from data
  input  wire logic        i_sp_we,          // Write current stack pointer
  input  wire logic [31:0] i_sp_wdata,       // Stack pointer value
  output logic [31:0]      o_sp,             // Current stack pointer
  input  wire logic        i_lr_we,          // Link register write
  input  wire logic [31:0] i_lr_wdata,       // Link register value
  output logic [31:0]      o_lr,             // Link register
  input  wire logic        i_pc_we,          // Program counter write
  input  wire logic [31:0] i_pc_wdata,       // Program counter value
  output logic [31:0]      o_pc,             // Program counter
  input  wire logic        i_interwork,      // Branch-exchange or pop to pc
  input  wire logic        i_flags_we,       // Flags update from execute
  input  wire logic [3:0]  i_flags,          // Result flags N Z C V
  input  wire logic        i_isb,            // Barrier retiring
  input  wire logic        i_exc_entry,      // Exception entry
  input  wire logic [5:0]  i_exc_num,        // Entered exception number
  input  wire logic [31:0] i_exc_vector,     // Fetched handler vector
  input  wire logic        i_exc_return,     // Exception return
  input  wire logic [31:0] i_stacked_psr,    // Restored status word
  input  wire logic        i_ret_to_thread,  // Return lands in thread
  input  wire logic        i_ret_use_psp,    // Return selects process stack
  input  wire logic        i_exec_attempt,   // Instruction about to execute
  input  wire logic        i_multi_active,   // Multiple transfer in flight
  input  wire logic        i_irq_taken,      // Interrupt accepted
  input  wire logic        i_prio_configurable, // Candidate is configurable
  output logic             o_prio_block,     // Activation blocked
  output logic             o_severe_fault,   // State-bit fault pulse
  output logic             o_multi_restart,  // Restart from first transfer
  output logic [31:0]      o_stacked_psr,    // Status word to stack
  output logic             o_handler_mode,   // Handler mode
  output logic             o_use_psp         // Process stack in use
);

  ////////////////////////////////////////////////////////////////////////////
  boot_state_t boot_r, boot_nxt;
  word_t       msp_r, msp_nxt;
  word_t       psp_r, psp_nxt;
  word_t       lr_r, lr_nxt;
  word_t       pc_r, pc_nxt;
  logic [3:0]  flags_r, flags_nxt;
  logic [5:0]  excn_r, excn_nxt;
  logic        tbit_r, tbit_nxt;
  logic        pmask_r, pmask_nxt;
  logic        spsel_r, spsel_nxt;
  logic        active_psp_r, active_psp_nxt;
  logic        fault_r, fault_nxt;
  logic        restart_r, restart_nxt;
  logic        handler;
  word_t       rdata_nxt;
  // Views of the status word
  word_t       psr_full;
  word_t       f_view;
  word_t       n_view;

  assign handler = (excn_r != `EXC_NUM_THREAD);

  always_comb begin
    f_view = 32'h0000_0000;
    f_view[`FLAGS_MSB:`FLAGS_LSB] = flags_r;
  end

  always_comb begin
    n_view = 32'h0000_0000;
    n_view[`EXC_NUM_MSB:`EXC_NUM_LSB] = excn_r;
  end

  always_comb begin
    psr_full = f_view | n_view;
    psr_full[`EXEC_STATE_BIT] = tbit_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset fetch sequencer
  always_comb begin
    boot_nxt = boot_r;
    case (boot_r)
      RST_IDLE:     boot_nxt = RST_FETCH_SP;
      RST_FETCH_SP: if (i_vec_valid) boot_nxt = RST_FETCH_PC;
      RST_FETCH_PC: if (i_vec_valid) boot_nxt = RST_RUN;
      RST_RUN:      boot_nxt = RST_RUN;
      default:      boot_nxt = RST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset)
      boot_r <= RST_IDLE;
    else
      boot_r <= boot_nxt;
  end

  assign o_vec_req  = (boot_r == RST_FETCH_SP) || (boot_r == RST_FETCH_PC);
  assign o_vec_addr = (boot_r == RST_FETCH_PC) ? `RESET_PC_VECTOR_ADDR
                                               : `RESET_SP_VECTOR_ADDR;
  assign o_running  = (boot_r == RST_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Register next values
  always_comb begin
    msp_nxt = msp_r;
    psp_nxt = psp_r;
    lr_nxt = lr_r;
    pc_nxt = pc_r;
    flags_nxt = flags_r;
    excn_nxt = excn_r;
    tbit_nxt = tbit_r;
    pmask_nxt = pmask_r;
    spsel_nxt = spsel_r;
    active_psp_nxt = active_psp_r;

    if (boot_r == RST_FETCH_SP && i_vec_valid)
      msp_nxt = i_vec_data;
    // Vector bit 0 is the state bit, never an address bit
    if (boot_r == RST_FETCH_PC && i_vec_valid) begin
      pc_nxt = {i_vec_data[31:1], 1'b0};
      tbit_nxt = i_vec_data[0];
    end
    if (o_running) begin
      if (i_sp_we) begin
        if (active_psp_r)
          psp_nxt = i_sp_wdata;
        else
          msp_nxt = i_sp_wdata;
      end

      if (i_lr_we)
        lr_nxt = i_lr_wdata;

      // Plain writes keep the state bit; only interworking moves it
      if (i_pc_we) begin
        pc_nxt = {i_pc_wdata[31:1], 1'b0};
        if (i_interwork)
          tbit_nxt = i_pc_wdata[0];
      end

      if (i_flags_we)
        flags_nxt = i_flags;

      if (i_msr_we) begin
        case (i_sel)
          `SEL_COMBINED, `SEL_FLAGS, `SEL_FLAGS_NUMBER, `SEL_FLAGS_STATE:
            flags_nxt = i_wdata[`FLAGS_MSB:`FLAGS_LSB];
          `SEL_MAIN_SP:    msp_nxt = i_wdata;
          `SEL_PROCESS_SP: psp_nxt = i_wdata;
          `SEL_PRIORITY_MASK_REG:    pmask_nxt = i_wdata[`PRIORITY_MASK_REG_BIT];
          `SEL_CONTROL:
            if (!handler)
              spsel_nxt = i_wdata[`STACK_SEL_BIT];
          default: ;
        endcase
      end

      // Stack choice takes effect only at a barrier
      if (i_isb)
        active_psp_nxt = spsel_nxt && !handler;

      // Entry wins over return in the same cycle
      if (i_exc_entry) begin
        excn_nxt = i_exc_num;
        tbit_nxt = i_exc_vector[0];
        spsel_nxt = 1'b0;
        active_psp_nxt = 1'b0;
      end else if (i_exc_return) begin
        flags_nxt = i_stacked_psr[`FLAGS_MSB:`FLAGS_LSB];
        tbit_nxt = i_stacked_psr[`EXEC_STATE_BIT];
        excn_nxt = i_ret_to_thread ? `EXC_NUM_THREAD
                                   : i_stacked_psr[`EXC_NUM_MSB:`EXC_NUM_LSB];
        spsel_nxt = i_ret_to_thread && i_ret_use_psp;
        active_psp_nxt = i_ret_to_thread && i_ret_use_psp;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-cycle pulses for the fault and the restart
  always_comb begin
    fault_nxt   = o_running && i_exec_attempt && !tbit_r;
    restart_nxt = o_running && i_irq_taken && i_multi_active;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      fault_r <= 1'b0;
      restart_r <= 1'b0;
    end else begin
      fault_r <= fault_nxt;
      restart_r <= restart_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      msp_r <= 32'h0000_0000;
      psp_r <= 32'h0000_0000;
      pc_r <= 32'h0000_0000;
      flags_r <= 4'h0;
      excn_r <= `EXC_NUM_THREAD;
      tbit_r <= 1'b0;
      pmask_r <= `PRIORITY_MASK_REG_RESET;
      spsel_r <= `STACK_SEL_RESET;
      active_psp_r <= 1'b0;
    end else begin
      msp_r <= msp_nxt;
      psp_r <= psp_nxt;
      pc_r <= pc_nxt;
      flags_r <= flags_nxt;
      excn_r <= excn_nxt;
      tbit_r <= tbit_nxt;
      pmask_r <= pmask_nxt;
      spsel_r <= spsel_nxt;
      active_psp_r <= active_psp_nxt;
    end
  end

  // Link register is deliberately left without reset
  always_ff @(posedge i_clk) begin
    lr_r <= lr_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read views; the state bit never shows to software
  // Read data holds until the next read
  always_comb begin
    rdata_nxt = o_rdata;
    if (i_mrs_re) begin
      case (i_sel)
        `SEL_COMBINED:     rdata_nxt = f_view | n_view;
        `SEL_FLAGS:        rdata_nxt = f_view;
        `SEL_NUMBER:       rdata_nxt = n_view;
        `SEL_STATE:        rdata_nxt = 32'h0000_0000;
        `SEL_FLAGS_NUMBER: rdata_nxt = f_view | n_view;
        `SEL_FLAGS_STATE:  rdata_nxt = f_view;
        `SEL_NUMBER_STATE: rdata_nxt = n_view;
        `SEL_MAIN_SP:      rdata_nxt = msp_r;
        `SEL_PROCESS_SP:   rdata_nxt = psp_r;
        `SEL_PRIORITY_MASK_REG:      rdata_nxt = {31'h0, pmask_r};
        `SEL_CONTROL:
          rdata_nxt = {30'h0, spsel_r && !handler, 1'b0};
        default:           rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset)
      o_rdata <= 32'h0000_0000;
    else
      o_rdata <= rdata_nxt;
  end

  assign o_sp            = active_psp_r ? psp_r : msp_r;
  assign o_lr            = lr_r;
  assign o_pc            = pc_r;
  assign o_prio_block    = pmask_r && i_prio_configurable;
  assign o_severe_fault  = fault_r;
  assign o_multi_restart = restart_r;
  assign o_stacked_psr   = psr_full;
  assign o_handler_mode  = handler;
  assign o_use_psp       = active_psp_r;

endmodule

// ### src/core_special_registers_defs.svh
// Offsets, field positions, reset values and selectors of the special-register set.
// Included by its bare name; only the register module uses it.
`ifndef CORE_SPECIAL_REGISTERS_DEFS_SVH
`define CORE_SPECIAL_REGISTERS_DEFS_SVH

`define RESET_SP_VECTOR_ADDR 32'h0000_0000
`define RESET_PC_VECTOR_ADDR 32'h0000_0004
`define FLAG_N_BIT           31
`define FLAG_Z_BIT           30
`define FLAG_C_BIT           29
`define FLAG_V_BIT           28
`define FLAGS_MSB            31
`define FLAGS_LSB            28
`define EXC_NUM_MSB          5
`define EXC_NUM_LSB          0
`define EXEC_STATE_BIT       24
`define STACK_SEL_BIT        1
`define PRIORITY_MASK_REG_BIT          0
`define PRIORITY_MASK_REG_RESET        1'b0
`define STACK_SEL_RESET      1'b0
`define EXC_NUM_THREAD       6'h00

`define SEL_COMBINED         4'h0
`define SEL_FLAGS            4'h1
`define SEL_NUMBER           4'h2
`define SEL_STATE            4'h3
`define SEL_FLAGS_NUMBER     4'h4
`define SEL_FLAGS_STATE      4'h5
`define SEL_NUMBER_STATE     4'h6
`define SEL_MAIN_SP          4'h7
`define SEL_PROCESS_SP       4'h8
`define SEL_PRIORITY_MASK_REG          4'h9
`define SEL_CONTROL          4'ha

`endif

// ### src/core_special_registers_pkg.sv
// Types shared by the special-register set and its users.
// Assumes the defines header lies on the include path.
package core_special_registers_pkg;
  typedef enum logic [1:0] {
    RST_IDLE,
    RST_FETCH_SP,
    RST_FETCH_PC,
    RST_RUN
  } boot_state_t;
  typedef logic [31:0] word_t;
endpackage

// ### test/core_special_registers_sva.sv
// Checker for the special-register set: boot fetch, status word, modes.
// Bound to the top module; sees its ports only.
`timescale 1ns/10ps
module core_special_registers_sva (
  input wire logic        i_clk,               // Clock
  input wire logic        i_reset,             // Reset
  input wire logic        o_vec_req,           // Vector req
  input wire logic [31:0] o_vec_addr,          // Vector addr
  input wire logic        i_vec_valid,         // Vector valid
  input wire logic [31:0] i_vec_data,          // Vector word
  input wire logic        o_running,           // Boot done
  input wire logic [31:0] o_pc,                // Program counter
  input wire logic [31:0] o_stacked_psr,       // Status word
  input wire logic        i_exc_entry,         // Entry
  input wire logic [5:0]  i_exc_num,           // Entry number
  input wire logic        o_handler_mode,      // Handler
  input wire logic        o_use_psp,           // Process stack
  input wire logic        i_exec_attempt,      // Execute
  input wire logic        o_severe_fault,      // Fault
  input wire logic        i_multi_active,      // Multi transfer
  input wire logic        i_irq_taken,         // Interrupt
  input wire logic        o_multi_restart,     // Restart
  input wire logic        i_prio_configurable, // Configurable
  input wire logic        o_prio_block         // Blocked
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  wire logic fault_cause = i_exec_attempt & ~o_stacked_psr[24];
  wire logic restart_cause = i_multi_active & i_irq_taken;
  wire logic vec_bit0 = i_vec_data[0];
  AST_RESET_STATE: assert property (
    $past(i_reset) |-> !o_running && !o_use_psp && !o_handler_mode
    && !o_prio_block) else $error("state after reset wrong");
  AST_BOOT_SP: assert property (
    o_vec_req && i_vec_valid && o_vec_addr == 32'h0 |=> o_vec_req
    && o_vec_addr == 32'h4 && !o_running) else $error("boot order wrong");
  AST_BOOT_PC: assert property (
    o_vec_req && i_vec_valid && o_vec_addr == 32'h4 |=> o_running
    && o_pc == ($past(i_vec_data) & 32'hffff_fffe)
    && o_stacked_psr[24] == $past(vec_bit0)) else $error("boot load wrong");
  AST_RSVD: assert property (
    o_stacked_psr[27:25] == 3'h0 && o_stacked_psr[23:6] == 18'h0)
    else $error("reserved status bits set");
  AST_ENTRY: assert property (
    o_running && i_exc_entry |=> o_stacked_psr[5:0] == $past(i_exc_num)
    && o_handler_mode && !o_use_psp) else $error("entry state wrong");
  AST_HANDLER_MSP: assert property (
    o_handler_mode |-> !o_use_psp) else $error("process stack in handler");
  AST_FAULT: assert property (
    o_running |=> o_severe_fault == $past(fault_cause))
    else $error("fault pulse wrong");
  AST_RESTART: assert property (
    o_running |=> o_multi_restart == $past(restart_cause))
    else $error("restart pulse wrong");
  AST_PRIO: assert property (
    !i_prio_configurable |-> !o_prio_block) else $error("fixed blocked");
endmodule
bind core_special_registers core_special_registers_sva u_sva (.*);

// ### test/test_core_special_registers.sv
// Self-checking bench for the special-register set against a bench model.
// Drives all ports at the rising edge; the checker is bound on its own.
`timescale 1ns/10ps
module test_core_special_registers;
  import core_special_registers_pkg::*;
  logic        i_clk = 1'b0, i_reset = 1'b1, i_vec_valid = 1'b0;
  logic        i_prio_configurable = 1'b0, i_ret_to_thread = 1'b1;
  logic        i_ret_use_psp = 1'b0, r, t, pm = 1'b0, act = 1'b0;
  logic        pc_ok = 1'b0, lr_ok = 1'b0;
  logic [12:0] p = '0;
  logic        i_msr_we, i_mrs_re, i_sp_we, i_lr_we, i_pc_we, i_interwork;
  logic        i_flags_we, i_isb, i_exc_entry, i_exc_return;
  logic        i_exec_attempt, i_multi_active, i_irq_taken;
  logic        o_vec_req, o_running, o_prio_block, o_severe_fault;
  logic        o_multi_restart, o_handler_mode, o_use_psp;
  logic [3:0]  i_sel = '0, i_flags = '0, fl;
  logic [5:0]  i_exc_num = '0, num = '0;
  logic [1:0]  ctl = '0;
  word_t       i_vec_data = '0, i_wdata = '0, i_sp_wdata = '0, a, v;
  word_t       i_lr_wdata = '0, i_pc_wdata = '0, i_exc_vector = '0;
  word_t       i_stacked_psr = '0, main_stack_pointer, process_stack_pointer, pc, lr;
  word_t       o_vec_addr, o_rdata, o_sp, o_lr, o_pc, o_stacked_psr;
  int          err_total = 0, num_checks = 0, cyc = 0;
  int          nums[$] = '{2, 3, 11, 14, 15, 16, 24};
  assign {i_irq_taken, i_multi_active, i_exec_attempt, i_exc_return,
          i_exc_entry, i_isb, i_flags_we, i_interwork, i_pc_we, i_lr_we,
          i_sp_we, i_mrs_re, i_msr_we} = p;
  core_special_registers dut (.*);
  always #2.5 i_clk = ~i_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input word_t e, input word_t g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic word_t rd(input logic [3:0] s);
    case (s)
      4'h0, 4'h4: return {fl, 22'h0, num};
      4'h1, 4'h5: return {fl, 28'h0};
      4'h2, 4'h6: return {26'h0, num};
      4'h7: return main_stack_pointer;
      4'h8: return process_stack_pointer;
      4'h9: return {31'h0, pm};
      4'ha: return {30'h0, ctl};
      default: return '0;
    endcase
  endfunction
  task automatic upd(input logic [12:0] m);
    if (m[0]) begin
      case (i_sel)
        4'h0, 4'h1, 4'h4, 4'h5: fl = i_wdata[31:28];
        4'h7: main_stack_pointer = i_wdata;
        4'h8: process_stack_pointer = i_wdata;
        4'h9: pm = i_wdata[0];
        4'ha: if (num == 6'h0) ctl = {i_wdata[1], 1'b0};
        default: ;
      endcase
    end
    if (m[2] && act) process_stack_pointer = i_sp_wdata;
    if (m[2] && !act) main_stack_pointer = i_sp_wdata;
    if (m[3]) lr = i_lr_wdata;
    lr_ok |= m[3];
    if (m[4]) pc = i_pc_wdata & 32'hffff_fffe;
    if (m[5]) t = i_pc_wdata[0];
    if (m[6]) fl = i_flags;
    if (m[7]) act = ctl[1] && num == 6'h0;
    if (m[8]) begin
      num = i_exc_num;
      ctl = 2'h0;
      act = 1'b0;
      t = i_exc_vector[0];
      pc_ok = 1'b0;
    end else if (m[9]) begin
      num = i_ret_to_thread ? 6'h0 : i_stacked_psr[5:0];
      ctl = {i_ret_to_thread & i_ret_use_psp, 1'b0};
      act = i_ret_to_thread & i_ret_use_psp;
      fl = i_stacked_psr[31:28];
      t = i_stacked_psr[24];
    end
    pc_ok |= m[4];
  endtask
  task automatic cmp(input logic [12:0] m);
    word_t e, g;
    e = {27'h0, num != 6'h0, act, pm & i_prio_configurable, m[10] & ~t,
         m[11] & m[12]};
    g = {27'h0, o_handler_mode, o_use_psp, o_prio_block, o_severe_fault,
         o_multi_restart};
    chk("modes", e, g);
    chk("sp", act ? process_stack_pointer : main_stack_pointer, o_sp);
    if (pc_ok) chk("pc", pc, o_pc);
    if (lr_ok) chk("lr", lr, o_lr);
    chk("psr", {fl, 3'h0, t, 18'h0, num}, o_stacked_psr);
    if (m[1]) chk("rdata", rd(i_sel), o_rdata);
  endtask
  // Entered at a rising edge, returns at one, so calls chain cleanly
  task automatic fire(input logic [12:0] m);
    p <= m;
    @(posedge i_clk);
    p <= '0;
    upd(m);
    @(negedge i_clk);
    cmp(m);
    @(posedge i_clk);
  endtask
  task automatic rd_all;
    for (int s = 0; s < 16; s++) begin
      i_sel <= 4'(s);
      fire(13'h2);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      finish_test;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h2522));
    repeat (8) @(posedge i_clk);
    i_reset <= 1'b0;
    @(negedge i_clk);
    chk("running", 32'h0, {31'h0, o_running});
    main_stack_pointer = $urandom;
    v = $urandom | 32'h1;
    // Vector answers come a cycle late, one pulse per word
    repeat (7) begin
      @(negedge i_clk);
      r = o_vec_req;
      a = o_vec_addr;
      @(posedge i_clk);
      i_vec_valid <= r & ~i_vec_valid;
      i_vec_data <= (a == 32'h4) ? v : main_stack_pointer;
    end
    pc = v & 32'hffff_fffe;
    t = 1'b1;
    pc_ok = 1'b1;
    i_flags <= 4'($urandom);
    fire(13'h40);
    i_sel <= 4'h9;
    fire(13'h2);
    i_sel <= 4'ha;
    fire(13'h2);
    i_sel <= 4'h8;
    i_wdata <= $urandom;
    fire(13'h1);
    for (int s = 0; s < 16; s++) begin
      i_sel <= 4'(s);
      i_wdata <= $urandom;
      fire(13'h1);
      rd_all;
    end
    i_sel <= 4'ha;
    i_wdata <= 32'hffff_ffff;
    fire(13'h1);
    fire(13'h80);
    i_sp_wdata <= $urandom;
    i_lr_wdata <= $urandom;
    fire(13'hc);
    i_sel <= 4'h9;
    i_prio_configurable <= 1'b1;
    fire(13'h1);
    foreach (nums[k]) begin
      i_exc_num <= 6'(nums[k]);
      i_exc_vector <= $urandom;
      i_prio_configurable <= k[0];
      fire(13'h100);
      i_sel <= 4'ha;
      i_wdata <= 32'h2;
      fire(13'h401);
      rd_all;
      i_stacked_psr <= {fl, 3'h0, 1'($urandom), 18'h0, 6'(nums[k])};
      i_ret_use_psp <= k[0];
      i_ret_to_thread <= !k[1];
      fire(13'h200);
      i_pc_wdata <= $urandom;
      fire(13'h1830);
      fire(13'hc00);
    end
    finish_test;
  end
endmodule
